// ### pyro_motion_defines.vh
// constants for the pyro motion engine control block
//
// Contract
// - first sensor input pin is dedicated to the sensor adc channel only
// - dual mode takes second sensor input for sensor two, alternate functions lost
// - engine enabled drives external reference pin as reference output; code drives it only with the big package bit set
// - dual mode releases external reference pin to the application
// - init routine switches every involved pin to the mode's function
// - adc differential buffered, sensor one plus, reference minus in single mode
// - dual mode puts sensor two on minus input, reference only internal
// - two-bit extended detection field in bits 7..6 selects sensitivity 0..3
// - higher extended level gives range setting less influence
// - enable pattern clears disabled bit; disable pattern sets it, engine idles
// - frequency response field 0..12; higher accepts lower frequencies
// - scan rate 0 converts continuously, new start every 256 clocks
// - every completed conversion raises an interrupt serviced by the routine
// - scan rate 1 uses single shots of 5129 clocks each
// - low rate keeps converter powered down between conversions
// - interference immunity disabled while low scan rate selected
// - scan rate change suppresses motion detection for up to 200 ms
`ifndef PYRO_MOTION_DEFINES_VH
`define PYRO_MOTION_DEFINES_VH

// register indices (byte address = 4 * index)
`define ADDR_W            12
`define REG_SC0_IDX       12'h102
`define REG_RANGE_IDX     12'h104
`define REG_FREQ_IDX      12'h105
`define REG_ENABLE_IDX    12'h106
`define REG_CONV_CTL_IDX  12'h107
`define REG_PIN_IDX       12'h108
`define REG_RESULT_IDX    12'h109

// status/control 0 fields
`define SC0_EXT_HI        7
`define SC0_EXT_LO        6
`define SC0_DISABLED      5
`define SC0_RESET         8'h20

// frequency/rate register fields
`define FR_FREQ_HI        6
`define FR_FREQ_LO        3
`define FR_SCAN_RATE      2
`define FREQ_MAX          4'hC
`define FR_RESET          8'h00

// converter control: start bit
`define CC_START          7

// pattern values written to the enable register (arbitrary)
`define ENGINE_ON_PATTERN  8'hA5
`define ENGINE_OFF_PATTERN 8'h5A

// pin control register bits
`define PIN_DUAL          0
`define PIN_BIG_PKG       1
`define PIN_INIT          2

// timing
`define CLK_MHZ           200
`define NORMAL_PERIOD_CLK 256
`define SINGLE_SHOT_CLK   5129
`define SUPPRESS_MS       200
`define SUPPRESS_CLK      (`SUPPRESS_MS * 1000 * `CLK_MHZ)

`endif

// ### conv_timer.v
// conversion pacing timer: continuous or single shot
`timescale 1ns/1ps
`include "pyro_motion_defines.vh"
module conv_timer #(
    parameter NORMAL_CLK = `NORMAL_PERIOD_CLK,
    parameter SHOT_CLK   = `SINGLE_SHOT_CLK
) (
    input  wire        clk_in,
    input  wire        sys_rst_in,
    input  wire        run_in,
    input  wire        low_rate_in,
    input  wire        start_in,
    output reg         done_out,
    output reg         busy_out,
    output reg         power_out
);
    reg [12:0] cnt_r;
    reg        low_q_r; // rate seen last cycle

    // counts a conversion; restarts itself only in normal rate
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r     <= 13'h0000;
            done_out  <= 1'b0;
            busy_out  <= 1'b0;
            power_out <= 1'b0;
            low_q_r   <= 1'b0;
        end else begin
            done_out <= 1'b0;
            low_q_r  <= low_rate_in;
            if (!run_in) begin
                cnt_r     <= 13'h0000;
                busy_out  <= 1'b0;
                power_out <= 1'b0;
            end else if (!low_rate_in) begin
                power_out <= 1'b1;
                busy_out  <= 1'b1;
                if (cnt_r >= NORMAL_CLK[12:0] - 13'h0001) begin
                    cnt_r    <= 13'h0000;
                    done_out <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 13'h0001;
                end
            end else if (busy_out && low_q_r) begin
                // first low-rate cycle drops the free run: no shot without a start
                if (cnt_r >= SHOT_CLK[12:0] - 13'h0001) begin
                    cnt_r     <= 13'h0000;
                    busy_out  <= 1'b0;
                    power_out <= 1'b0;
                    done_out  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 13'h0001;
                end
            end else begin
                cnt_r     <= 13'h0000;
                power_out <= start_in;
                busy_out  <= start_in;
            end
        end
    end
endmodule // conv_timer

// ### sync2.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter W = 1
) (
    input  wire         clk_in,
    input  wire         sys_rst_in,
    input  wire [W-1:0] d_in,
    output reg  [W-1:0] q_out
);
    reg [W-1:0] meta_r;

    // first stage is read only by the second
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_r <= {W{1'b0}};
            q_out  <= {W{1'b0}};
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule // sync2

// ### pyro_motion_engine_control.v
// pyro motion engine control: registers, pin routing, conversion pacing
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "pyro_motion_defines.vh"
module pyro_motion_engine_control #(
    parameter SUPPRESS_CYCLES = `SUPPRESS_CLK
) (
    input  wire        clk_in,
    input  wire        sys_rst_in,
    input  wire [11:0] addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [7:0]  rdata_out,
    input  wire        motion_raw_in,
    output reg         conv_irq_out,
    output reg         adc_power_out,
    output reg         adc_diff_buf_out,
    output reg         adc_pos_sel_out,
    output reg         adc_neg_sel_out,
    output reg         vref_int_en_out,
    output reg         first_sensor_ana_out,
    output reg         second_sensor_ana_out,
    output reg         vref_pin_oe_out,
    output reg         vref_pin_app_out,
    output reg         emi_immune_out,
    output reg         motion_detected_out,
    output reg  [1:0]  range_weight_out,
    output reg  [3:0]  freq_resp_out
);
    // ************************************************************
    // state and declarations
    // ************************************************************
    localparam ST_OFF  = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_STOP = 3'b100;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [1:0]  ext_level_r;
    reg         disabled_r;
    reg  [1:0]  range_r;
    reg  [3:0]  freq_r;
    reg         low_rate_r;
    reg         start_req_r;
    reg         dual_r;
    reg         big_pkg_r;
    reg         pin_dual_r;
    reg         pin_big_r;
    reg         off_req_r;
    reg  [7:0]  result_r;
    reg  [31:0] suppress_r;
    reg         motion_flag_r;
    wire        motion_sync;
    wire        conv_done;
    wire        conv_busy;
    wire        conv_power;
    wire        run;

    // ************************************************************
    // address decode
    // ************************************************************
    function is_reg;
        input [11:0] a;
        input [11:0] idx;
        begin
            is_reg = (a == idx);
        end
    endfunction

    assign run = (state_r == ST_RUN);

    // ************************************************************
    // engine state machine
    // ************************************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF:  begin
                if (wr_in && is_reg(addr_in, `REG_ENABLE_IDX)
                    && wdata_in == `ENGINE_ON_PATTERN) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN:  begin
                // the off request is seen at the next completed conversion
                if (off_req_r && conv_done) begin
                    state_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                state_nxt = ST_OFF;
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
    end

    // ************************************************************
    // register writes and engine status
    // ************************************************************
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r     <= ST_OFF;
            ext_level_r <= 2'h0;
            disabled_r  <= 1'b1;
            range_r     <= 2'h0;
            freq_r      <= 4'h0;
            low_rate_r  <= 1'b0;
            start_req_r <= 1'b0;
            dual_r      <= 1'b0;
            big_pkg_r   <= 1'b0;
            pin_dual_r  <= 1'b0;
            pin_big_r   <= 1'b0;
            off_req_r   <= 1'b0;
            suppress_r  <= 32'h0000_0000;
        end else begin
            state_r     <= state_nxt;
            start_req_r <= 1'b0;
            if (state_r == ST_OFF && state_nxt == ST_RUN) begin
                disabled_r <= 1'b0;
                off_req_r  <= 1'b0;
                pin_dual_r <= dual_r;
                pin_big_r  <= big_pkg_r;
            end
            if (state_r == ST_STOP) begin
                disabled_r <= 1'b1;
                off_req_r  <= 1'b0;
            end
            if (wr_in) begin
                if (is_reg(addr_in, `REG_SC0_IDX)) begin
                    ext_level_r <= wdata_in[`SC0_EXT_HI:`SC0_EXT_LO];
                end
                if (is_reg(addr_in, `REG_RANGE_IDX)) begin
                    range_r <= wdata_in[1:0];
                end
                if (is_reg(addr_in, `REG_FREQ_IDX)) begin
                    // values above twelve are clipped
                    freq_r <= (wdata_in[`FR_FREQ_HI:`FR_FREQ_LO] > `FREQ_MAX)
                              ? `FREQ_MAX : wdata_in[`FR_FREQ_HI:`FR_FREQ_LO];
                    low_rate_r <= wdata_in[`FR_SCAN_RATE];
                    if (run && wdata_in[`FR_SCAN_RATE] != low_rate_r) begin
                        suppress_r <= SUPPRESS_CYCLES;
                    end
                end
                if (is_reg(addr_in, `REG_ENABLE_IDX)
                    && wdata_in == `ENGINE_OFF_PATTERN && run) begin
                    off_req_r <= 1'b1;
                end
                if (is_reg(addr_in, `REG_CONV_CTL_IDX)) begin
                    start_req_r <= wdata_in[`CC_START] & low_rate_r;
                end
                if (is_reg(addr_in, `REG_PIN_IDX)) begin
                    dual_r    <= wdata_in[`PIN_DUAL];
                    big_pkg_r <= wdata_in[`PIN_BIG_PKG];
                    if (wdata_in[`PIN_INIT] && run) begin
                        pin_dual_r <= wdata_in[`PIN_DUAL];
                        pin_big_r  <= wdata_in[`PIN_BIG_PKG];
                    end
                end
            end
            if (!(wr_in && is_reg(addr_in, `REG_FREQ_IDX)) && suppress_r != 32'h0000_0000) begin
                suppress_r <= suppress_r - 32'h0000_0001;
            end
        end
    end

    // ************************************************************
    // conversion pacing and motion input
    // ************************************************************
    conv_timer u_timer (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .run_in      (run),
        .low_rate_in (low_rate_r),
        .start_in    (start_req_r),
        .done_out    (conv_done),
        .busy_out    (conv_busy),
        .power_out   (conv_power)
    );

    sync2 #(.W(1)) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (motion_raw_in),
        .q_out      (motion_sync)
    );

    // ************************************************************
    // conversion result and motion flag
    // ************************************************************
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            result_r      <= 8'h00;
            motion_flag_r <= 1'b0;
        end else begin
            if (conv_done && run) begin
                result_r <= result_r + 8'h01;
                // suppressed during a rate change
                motion_flag_r <= motion_sync && (suppress_r == 32'h0000_0000);
            end
        end
    end

    // ************************************************************
    // registered outputs: pins, adc routing, status
    // ************************************************************
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            conv_irq_out          <= 1'b0;
            adc_power_out         <= 1'b0;
            adc_diff_buf_out      <= 1'b0;
            adc_pos_sel_out       <= 1'b0;
            adc_neg_sel_out       <= 1'b0;
            vref_int_en_out       <= 1'b0;
            first_sensor_ana_out  <= 1'b0;
            second_sensor_ana_out <= 1'b0;
            vref_pin_oe_out       <= 1'b0;
            vref_pin_app_out      <= 1'b1;
            emi_immune_out        <= 1'b0;
            motion_detected_out   <= 1'b0;
            range_weight_out      <= 2'h0;
            freq_resp_out         <= 4'h0;
        end else begin
            conv_irq_out          <= conv_done && run;
            adc_power_out         <= conv_power;
            adc_diff_buf_out      <= run;
            adc_pos_sel_out       <= 1'b0;
            adc_neg_sel_out       <= run && pin_dual_r;
            vref_int_en_out       <= run;
            first_sensor_ana_out  <= 1'b1;
            second_sensor_ana_out <= run && pin_dual_r;
            vref_pin_oe_out       <= run && pin_big_r && !pin_dual_r;
            vref_pin_app_out      <= !(run && pin_big_r && !pin_dual_r);
            emi_immune_out        <= run && !low_rate_r;
            motion_detected_out   <= motion_flag_r && run && (suppress_r == 32'h0000_0000);
            range_weight_out      <= (ext_level_r >= range_r) ? 2'h0 : range_r - ext_level_r;
            freq_resp_out         <= freq_r;
        end
    end

    // ************************************************************
    // read port: data in the cycle after the strobe
    // ************************************************************
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `REG_SC0_IDX:      rdata_out <= {ext_level_r, disabled_r, 3'h0,
                                                 motion_flag_r, 1'b0};
                `REG_RANGE_IDX:    rdata_out <= {6'h00, range_r};
                `REG_FREQ_IDX:     rdata_out <= {1'b0, freq_r, low_rate_r, 2'h0};
                `REG_CONV_CTL_IDX: rdata_out <= {conv_busy, 7'h00};
                `REG_PIN_IDX:      rdata_out <= {5'h00, 1'b0, pin_big_r, pin_dual_r};
                `REG_RESULT_IDX:   rdata_out <= result_r;
                default:           rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule // pyro_motion_engine_control

// ### pyro_motion_checker.sv
// checker: port-level properties of the motion engine control block
`timescale 1ns/1ps
module pyro_motion_checker (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       conv_irq_out,
    input wire logic       adc_power_out,
    input wire logic       adc_diff_buf_out,
    input wire logic       adc_pos_sel_out,
    input wire logic       adc_neg_sel_out,
    input wire logic       vref_int_en_out,
    input wire logic       first_sensor_ana_out,
    input wire logic       second_sensor_ana_out,
    input wire logic       vref_pin_oe_out,
    input wire logic       vref_pin_app_out,
    input wire logic       emi_immune_out,
    input wire logic       motion_detected_out,
    input wire logic [3:0] freq_resp_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ****************************************
    // sequences
    // ****************************************
    sequence s_pulse_end; ##1 !conv_irq_out; endsequence
    sequence s_next_conv; ##256 (conv_irq_out || !emi_immune_out); endsequence
    sequence s_shot_off; ##2 !adc_power_out; endsequence
    // ****************************************
    // properties
    // ****************************************
    property p_irq_pulse; conv_irq_out |-> s_pulse_end; endproperty
    property p_period; conv_irq_out && emi_immune_out |-> s_next_conv; endproperty
    property p_low_off; conv_irq_out && !emi_immune_out && adc_diff_buf_out |-> s_shot_off;
    endproperty
    property p_first_pin; $past(!sys_rst_in) |-> first_sensor_ana_out; endproperty
    property p_vref_out;
        vref_pin_oe_out |-> !vref_pin_app_out && !second_sensor_ana_out && !adc_neg_sel_out;
    endproperty
    property p_dual;
        second_sensor_ana_out |-> adc_neg_sel_out && vref_int_en_out && vref_pin_app_out;
    endproperty
    property p_pos; adc_diff_buf_out |-> !adc_pos_sel_out; endproperty
    property p_freq; freq_resp_out <= 4'hC; endproperty
    property p_idle_motion; motion_detected_out |-> adc_diff_buf_out; endproperty
    property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("conversion pulse longer than one cycle");
    a_period: assert property (p_period)
        else $error("continuous conversion period not 256");
    a_low_off: assert property (p_low_off)
        else $error("converter left powered after single shot");
    a_first_pin: assert property (p_first_pin)
        else $error("first sensor pin not dedicated");
    a_vref_out: assert property (p_vref_out)
        else $error("reference pin driven while released");
    a_dual: assert property (p_dual)
        else $error("dual routing wrong");
    a_pos: assert property (p_pos)
        else $error("plus input not on first sensor");
    a_freq: assert property (p_freq)
        else $error("frequency response above twelve");
    a_idle_motion: assert property (p_idle_motion)
        else $error("motion flagged while engine idle");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read answer cycle");
endmodule // pyro_motion_checker

bind pyro_motion_engine_control pyro_motion_checker chk_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .conv_irq_out(conv_irq_out), .adc_power_out(adc_power_out),
    .adc_diff_buf_out(adc_diff_buf_out), .adc_pos_sel_out(adc_pos_sel_out),
    .adc_neg_sel_out(adc_neg_sel_out), .vref_int_en_out(vref_int_en_out),
    .first_sensor_ana_out(first_sensor_ana_out), .second_sensor_ana_out(second_sensor_ana_out),
    .vref_pin_oe_out(vref_pin_oe_out), .vref_pin_app_out(vref_pin_app_out),
    .emi_immune_out(emi_immune_out), .motion_detected_out(motion_detected_out),
    .freq_resp_out(freq_resp_out)
);

// ### pyro_sensor_model.sv
// pyroelectric sensor model: motion level reaching the raw motion pin
`timescale 1ns/1ps
module pyro_sensor_model #(
    parameter LAG = 3
) (
    input  wire logic clk_in,
    input  wire logic warm_in,
    output wire logic level_out
);
    logic [LAG-1:0] sh_r;
    // sensor answers late: warmth reaches the pin after LAG clocks
    initial sh_r = '0;
    always @(posedge clk_in) begin
        sh_r <= {sh_r[LAG-2:0], warm_in};
    end
    assign level_out = sh_r[LAG-1];
endmodule // pyro_sensor_model

// ### pyro_motion_engine_control_tb_top.sv
// testbench: register, pin routing and conversion pacing checks
`timescale 1ns/1ps
module pyro_motion_engine_control_tb_top;
    logic        clk_in, sys_rst_in = 1, wr_in = 0, rd_in = 0, warm = 0;
    logic [11:0] addr_in = 12'h000;
    logic [7:0]  wdata_in = 8'h00, d;
    wire  [7:0]  rdata_out;
    wire  [1:0]  range_weight_out;
    wire  [3:0]  freq_resp_out;
    wire         motion_raw, conv_irq_out, adc_power_out, adc_diff_buf_out, adc_pos_sel_out;
    wire         adc_neg_sel_out, vref_int_en_out, first_sensor_ana_out, second_sensor_ana_out;
    wire         vref_pin_oe_out, vref_pin_app_out, emi_immune_out, motion_detected_out;
    integer      seed = 29, bad_count = 0, check_count = 0, cycles = 0, c, n, i, t;
    int          exp_q[$];
    pyro_motion_engine_control #(.SUPPRESS_CYCLES(50)) uut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .motion_raw_in(motion_raw),
        .conv_irq_out(conv_irq_out), .adc_power_out(adc_power_out),
        .adc_diff_buf_out(adc_diff_buf_out), .adc_pos_sel_out(adc_pos_sel_out),
        .adc_neg_sel_out(adc_neg_sel_out), .vref_int_en_out(vref_int_en_out),
        .first_sensor_ana_out(first_sensor_ana_out),
        .second_sensor_ana_out(second_sensor_ana_out), .vref_pin_oe_out(vref_pin_oe_out),
        .vref_pin_app_out(vref_pin_app_out), .emi_immune_out(emi_immune_out),
        .motion_detected_out(motion_detected_out), .range_weight_out(range_weight_out),
        .freq_resp_out(freq_resp_out));
    pyro_sensor_model sensor (.clk_in(clk_in), .warm_in(warm), .level_out(motion_raw));
    // ****************************************
    // clock, timeout and helpers
    // ****************************************
    initial begin
        clk_in = 0;
        forever #2.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            summarize;
        end
    end
    task summarize;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask
    task settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    // edges until the next conversion pulse, bounded
    task wait_irq(output integer k);
        k = 0;
        do begin
            @(posedge clk_in);
            #1 k = k + 1;
        end while (conv_irq_out !== 1'b1 && k < 6000);
    endtask
    task count_irq(input integer len, output integer k);
        k = 0;
        repeat (len) begin
            @(posedge clk_in);
            #1 k = k + (conv_irq_out === 1'b1);
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 0;
        settle;
        chk("first_pin", first_sensor_ana_out, 1);
        rd(12'h102, d); chk("sc0_reset", d, 8'h20);
        rd(12'h0FF, d); chk("unmapped", d, 8'h00);
        count_irq(600, n); chk("idle_conv", n, 0);
        wr(12'h108, 8'h02);
        wr(12'h106, 8'hA5);
        settle;
        rd(12'h102, d); chk("sc0_on", d, 8'h00);
        chk("single_pins", {vref_pin_oe_out, vref_pin_app_out, adc_diff_buf_out, adc_neg_sel_out,
            adc_pos_sel_out, emi_immune_out, second_sensor_ana_out}, 7'b1010010);
        wait_irq(c);
        wait_irq(c); chk("period", c, 256);
        for (i = 0; i < 4; i = i + 1) begin
            t = $random(seed) & 3;
            wr(12'h104, t[7:0]);
            wr(12'h102, i[1:0] << 6);
            settle;
            chk("range_weight", range_weight_out, (t > i) ? t - i : 0);
            rd(12'h102, d); chk("ext_level", d[7:6], i);
        end
        for (i = 0; i < 16; i = i + 1) begin
            exp_q.push_back(i > 12 ? 12 : i);
            wr(12'h105, i[3:0] << 3);
            settle;
            chk("freq_resp", freq_resp_out, exp_q.pop_front());
        end
        wr(12'h108, 8'h07);
        settle;
        chk("dual_pins", {second_sensor_ana_out, adc_neg_sel_out, vref_int_en_out,
            vref_pin_oe_out, vref_pin_app_out}, 5'b11101);
        warm <= 1'b1;
        wr(12'h105, 8'h04); // scan rate 1 selected, frequency field 0
        settle;
        chk("low_emi_pwr", {emi_immune_out, adc_power_out}, 2'b00);
        wr(12'h107, 8'h80); // start bit
        wait_irq(c); chk("shot_len", c >= 5126 && c <= 5132, 1);
        settle;
        chk("low_pwr_off", adc_power_out, 0);
        wr(12'h105, 8'h00);
        repeat (2) @(posedge clk_in);
        n = 0;
        repeat (40) begin
            @(posedge clk_in);
            #1 n = n + (motion_detected_out === 1'b1);
        end
        chk("suppressed", n, 0);
        wait_irq(c);
        wait_irq(c);
        #6 chk("motion_back", motion_detected_out, 1);
        wr(12'h106, 8'h5A);
        wait_irq(c); // service runs once after the request
        settle;
        rd(12'h102, d); chk("disabled_ack", d[5], 1);
        count_irq(600, n); chk("off_conv", n, 0);
        summarize;
    end
endmodule // pyro_motion_engine_control_tb_top
